//--- inc/pcr_consts.svh
// Constants for the positioner and cam reference generator.
// Assumes one 40 MHz clock and a synchronous active-high reset.
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH
`define PCR_TBL_DEPTH 64
`define PCR_TBL_AW 6
`define PCR_CAM_NUM 8
`define PCR_CAM_AW 3
`define PCR_CAM_PTS 576
`define PCR_PT_AW 10
`define PCR_START_INS 8
`define PCR_ADC_FULL 12'hfff
`define PCR_FRAC_SH 16
`define PCR_COUNTS_REV 32'h0000ffff
`define PCR_RST_POS 32'h00000000
`define PCR_RST_NPTS 10'h002
`define PCR_RST_RATIO 16'h0001
`endif

//--- inc/pcr_pkg.sv
// Types shared by the positioner and cam reference generator.
// Assumes the constants header is included alongside.
package pcr_pkg;
    // Position application selected by the configuration.
    typedef enum logic [2:0] {
        PCR_SINGLE, PCR_ANALOG, PCR_TSEL, PCR_TSEQ, PCR_TINPUT, PCR_CAM
    } pcr_mode_e;
    // Channel by which the drive is commanded.
    typedef enum logic [1:0] {PCR_SRC_IO, PCR_SRC_SERIAL, PCR_SRC_FIELDBUS} pcr_src_e;
    // Motion profile shape handed to the trajectory stage.
    typedef enum logic [1:0] {PCR_TRAPEZOID, PCR_RAMP, PCR_RAMP_LIMIT_A} pcr_prof_e;
    // Per-cam parameter set.
    typedef struct packed {
        logic [15:0] ratio_num;
        logic [15:0] ratio_den;
        logic [31:0] master_mod;
        logic [31:0] slave_mod;
        logic [9:0] npts;
        logic cubic;
    } pcr_cam_par_s;
    // Static positioner configuration.
    typedef struct packed {
        pcr_mode_e mode;
        pcr_src_e src;
        pcr_prof_e profile;
        logic spd_analog;
        logic cyclic;
        logic [6:0] seq_len;
        logic pulse_dir;
        logic [31:0] single_target;
        logic [31:0] analog_min;
        logic [31:0] analog_max;
        logic [15:0] int_speed;
    } pcr_cfg_s;
endpackage

//--- hw/pcr_frac_scale.sv
// Fractional pulse scaler: passes num out of every den input steps.
// Assumes num is not above den; den of zero passes every step.
`timescale 1ns/1ps
`include "pcr_consts.svh"
module pcr_frac_scale
    import pcr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic step_in,
    input wire logic dir_in,
    input wire logic [15:0] num,
    input wire logic [15:0] den,
    output logic step_out,
    output logic dir_out
);
    // Running remainder, one bit wider than the ratio fields.
    logic [16:0] acc_r;
    logic [16:0] acc_nxt;
    logic [16:0] acc_sum;
    logic pass;

    // A step passes once the remainder reaches the denominator.
    assign acc_sum = acc_r + {1'b0, num};
    assign pass = step_in && ((den == 16'h0000) || (acc_sum >= {1'b0, den}));
    assign acc_nxt = !step_in ? acc_r : (pass && den != 16'h0000) ? acc_sum - {1'b0, den} : acc_sum;

    // Output step and direction are registered for one cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            acc_r <= 17'h00000;
            step_out <= 1'b0;
            dir_out <= 1'b0;
        end else begin
            acc_r <= (den == 16'h0000) ? 17'h00000 : acc_nxt;
            step_out <= pass;
            dir_out <= dir_in;
        end
    end
endmodule

//--- hw/pcr_top.sv
// Target generator for positioner and electronic cam modes.
// Assumes all inputs are synchronous to sys_clk except the start, select and master reference pins.
`timescale 1ns/1ps
`include "pcr_consts.svh"
module pcr_top
    import pcr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire pcr_cfg_s cfg,
    input wire logic drive_en,
    input wire logic [11:0] aux_sample,
    input wire logic [15:0] main_speed,
    input wire logic start_in,
    input wire logic [5:0] sel_in,
    input wire logic [7:0] istart_in,
    input wire logic [7:0] istart_en,
    input wire logic tbl_we,
    input wire logic [5:0] tbl_addr,
    input wire logic [31:0] tbl_data,
    input wire logic cam_we,
    input wire logic [2:0] cam_wsel,
    input wire logic [9:0] cam_widx,
    input wire logic [15:0] cam_wdata,
    input wire logic par_we,
    input wire pcr_cam_par_s par_wdata,
    input wire logic [2:0] cam_sel,
    input wire logic [15:0] enc_num,
    input wire logic [15:0] enc_den,
    input wire logic engage_req,
    input wire logic [31:0] engage_pos,
    input wire logic [31:0] disengage_pos,
    input wire logic [31:0] phase_off,
    input wire logic quadrature_a,
    input wire logic quadrature_b,
    output logic [31:0] target_r,
    output logic move_r,
    output logic [15:0] speed_ref_r,
    output pcr_prof_e profile_r,
    output logic loops_en_r,
    output logic refused_r,
    output logic seq_done_r,
    output logic cam_engaged_r,
    output logic [31:0] master_pos_r
);
    // Target table and cam storage, all in flip-flops.
    logic [31:0] tbl_mem [`PCR_TBL_DEPTH];
    logic [15:0] cam_mem [`PCR_CAM_NUM][`PCR_CAM_PTS];
    pcr_cam_par_s par_mem [`PCR_CAM_NUM];

    // Synchroniser stages; stage one feeds stage two only.
    logic [15:0] sync1_r;
    logic [15:0] sync2_r;
    logic [15:0] sync3_r;
    logic [5:0] sel1_r;
    logic [5:0] sel2_r;
    logic [5:0] seq_idx_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync1_r <= 16'h0000;
            sync2_r <= 16'h0000;
            sync3_r <= 16'h0000;
            sel1_r <= 6'h00;
            sel2_r <= 6'h00;
        end else begin
            sync1_r <= {5'h00, quadrature_b, quadrature_a, start_in, istart_in};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            sel1_r <= sel_in;
            sel2_r <= sel1_r;
        end
    end

    // Rising edges seen once, from stages two and three only.
    logic start_rise;
    logic [7:0] in_rise;
    logic [2:0] in_idx;
    logic in_hit;
    assign start_rise = sync2_r[8] && !sync3_r[8];
    assign in_rise = sync2_r[7:0] & ~sync3_r[7:0] & istart_en;
    assign in_hit = |in_rise;

    // Lowest rising input wins when several rise together.
    always_comb begin
        in_idx = 3'h0;
        for (int i = `PCR_START_INS - 1; i >= 0; i--) begin
            if (in_rise[i]) begin
                in_idx = 3'(i);
            end
        end
    end

    // Mode permission by command channel.
    logic mode_ok;
    logic fb;
    logic is_cam;
    assign fb = (cfg.src == PCR_SRC_FIELDBUS);
    assign is_cam = (cfg.mode == PCR_CAM);
    assign mode_ok = !fb || cfg.mode == PCR_SINGLE || cfg.mode == PCR_TSEL;

    logic [31:0] span;
    logic [43:0] span_prod;
    logic [31:0] analog_tgt;
    assign span = cfg.analog_max - cfg.analog_min;
    assign span_prod = span * aux_sample;
    assign analog_tgt = cfg.analog_min + 32'(span_prod / 44'(`PCR_ADC_FULL));

    // Sequence bookkeeping for the cyclic or acyclic table walk.
    logic seq_last;
    logic [5:0] seq_idx_nxt;
    assign seq_last = ({1'b0, seq_idx_r} + 7'h01 >= cfg.seq_len);
    assign seq_idx_nxt = !seq_last ? seq_idx_r + 6'h01 : cfg.cyclic ? 6'h00 : seq_idx_r;

    // Positioner request decode: which move a start launches.
    logic pos_go;
    logic [31:0] pos_tgt;
    assign pos_go = mode_ok && drive_en && !is_cam && (cfg.mode == PCR_TINPUT ? in_hit : start_rise);
    always_comb begin
        pos_tgt = cfg.single_target;
        case (cfg.mode)
            PCR_SINGLE: pos_tgt = cfg.single_target;
            PCR_ANALOG: pos_tgt = analog_tgt;
            PCR_TSEL: pos_tgt = tbl_mem[sel2_r];
            PCR_TSEQ: pos_tgt = tbl_mem[seq_idx_r];
            // Entry tied to the rising input.
            PCR_TINPUT: pos_tgt = tbl_mem[{3'h0, in_idx}];
            default: pos_tgt = cfg.single_target;
        endcase
    end

    // Table and cam storage writes; a write in one cycle reads back the next.
    always_ff @(posedge sys_clk) begin
        if (tbl_we) begin
            tbl_mem[tbl_addr] <= tbl_data;
        end
        if (cam_we && cam_widx < 10'(`PCR_CAM_PTS)) begin
            cam_mem[cam_wsel][cam_widx] <= cam_wdata;
        end
    end

    // Per-cam parameters reset to a one-to-one ratio and one revolution.
    genvar g;
    generate
        for (g = 0; g < `PCR_CAM_NUM; g++) begin : g_par
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    par_mem[g] <= '{`PCR_RST_RATIO, `PCR_RST_RATIO, `PCR_COUNTS_REV, `PCR_COUNTS_REV,
                                   `PCR_RST_NPTS, 1'b0};
                end else if (par_we && cam_wsel == 3'(g)) begin
                    par_mem[g] <= par_wdata;
                end
            end
        end
    endgenerate

    pcr_cam_par_s act;
    assign act = par_mem[cam_sel];

    logic m_step;
    logic m_dir;
    logic qa_n;
    logic qb_n;
    logic qa_o;
    logic qb_o;
    assign qa_n = sync2_r[9];
    assign qb_n = sync2_r[10];
    assign qa_o = sync3_r[9];
    assign qb_o = sync3_r[10];
    // Pulse on the second pin, direction level on the first.
    assign m_step = cfg.pulse_dir ? (qb_n && !qb_o) : ((qa_n ^ qa_o) || (qb_n ^ qb_o));
    assign m_dir = cfg.pulse_dir ? qa_n : (qa_n ^ qb_o);

    logic e_step;
    logic e_dir;
    logic r_step;
    logic r_dir;
    pcr_frac_scale u_enc (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .step_in(m_step && is_cam),
        .dir_in(m_dir),
        .num(enc_num),
        .den(enc_den),
        .step_out(e_step),
        .dir_out(e_dir)
    );
    // Cam axis ratio of the active cam.
    pcr_frac_scale u_ratio (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .step_in(e_step),
        .dir_in(e_dir),
        .num(act.ratio_num),
        .den(act.ratio_den),
        .step_out(r_step),
        .dir_out(r_dir)
    );

    // Master index wraps in both directions.
    logic [31:0] mpos_nxt;
    logic [31:0] mmax;
    assign mmax = act.master_mod - 32'h00000001;
    assign mpos_nxt = !r_step ? master_pos_r :
                      r_dir ? ((master_pos_r >= mmax) ? 32'h00000000 : master_pos_r + 32'h00000001) :
                      ((master_pos_r == 32'h00000000) ? mmax : master_pos_r - 32'h00000001);

    logic [31:0] spacing;
    logic [31:0] seg32;
    logic [9:0] seg;
    logic [9:0] seg1;
    logic [31:0] frac;
    logic [15:0] t;
    logic [9:0] nseg;
    assign nseg = (act.npts > 10'h001) ? act.npts - 10'h001 : 10'h001;
    assign spacing = (act.master_mod / {22'h000000, nseg} == 32'h0) ? 32'h00000001 :
                     act.master_mod / {22'h000000, nseg};
    assign seg32 = master_pos_r / spacing;
    assign seg = (seg32 >= {22'h000000, nseg}) ? nseg - 10'h001 : seg32[9:0];
    assign seg1 = (seg + 10'h001 >= act.npts) ? 10'h000 : seg + 10'h001;
    assign frac = master_pos_r - 32'(seg * spacing);
    assign t = 16'({frac, 16'h0000} / {16'h0000, spacing});

    logic [15:0] p0;
    logic [15:0] p1;
    logic [31:0] tsq;
    logic [47:0] hcub;
    logic [15:0] w;
    logic signed [16:0] diff;
    logic signed [33:0] dprod;
    logic [15:0] pt_val;
    assign p0 = cam_mem[cam_sel][seg];
    assign p1 = cam_mem[cam_sel][seg1];
    assign tsq = t * t;
    assign hcub = {32'h00000000, tsq[31:16]} * (48'h000000030000 - {31'h00000000, t, 1'b0});
    // Cubic weight stays below one because t is below one.
    assign w = act.cubic ? hcub[31:16] : t;
    assign diff = $signed({1'b0, p1}) - $signed({1'b0, p0});
    assign dprod = diff * $signed({1'b0, w});
    assign pt_val = 16'($signed({1'b0, p0}) + 17'(dprod >>> `PCR_FRAC_SH));

    logic [47:0] sprod;
    logic [31:0] slave_pos;
    logic [31:0] cam_tgt;
    assign sprod = pt_val * act.slave_mod;
    assign slave_pos = sprod[47:16];
    assign cam_tgt = slave_pos + phase_off;

    logic eng_nxt;
    logic cam_run;
    assign cam_run = is_cam && mode_ok && drive_en;
    assign eng_nxt = !cam_run ? 1'b0 :
                     (!cam_engaged_r && engage_req && master_pos_r == engage_pos) ? 1'b1 :
                     (cam_engaged_r && !engage_req && master_pos_r == disengage_pos) ? 1'b0 :
                     cam_engaged_r;

    // Cam state: master index and coupling flag.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            master_pos_r <= `PCR_RST_POS;
            cam_engaged_r <= 1'b0;
        end else begin
            master_pos_r <= is_cam ? mpos_nxt : `PCR_RST_POS;
            cam_engaged_r <= eng_nxt;
        end
    end

    // Sequence index steps only on a launched sequenced move.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            seq_idx_r <= 6'h00;
            seq_done_r <= 1'b0;
        end else if (cfg.mode != PCR_TSEQ) begin
            seq_idx_r <= 6'h00;
            seq_done_r <= 1'b0;
        end else if (pos_go) begin
            seq_idx_r <= seq_idx_nxt;
            seq_done_r <= seq_last && !cfg.cyclic;
        end
    end

    // Output stage: target, move strobe, speed and loop enable.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            target_r <= `PCR_RST_POS;
            move_r <= 1'b0;
            speed_ref_r <= 16'h0000;
            profile_r <= PCR_TRAPEZOID;
            loops_en_r <= 1'b0;
            refused_r <= 1'b0;
        end else begin
            // A held acyclic end issues no further move.
            move_r <= pos_go && !(cfg.mode == PCR_TSEQ && seq_done_r);
            if (pos_go && !(cfg.mode == PCR_TSEQ && seq_done_r)) begin
                target_r <= pos_tgt;
            end else if (cam_engaged_r) begin
                target_r <= cam_tgt;
            end
            speed_ref_r <= cfg.spd_analog ? main_speed : cfg.int_speed;
            profile_r <= cfg.profile;
            loops_en_r <= mode_ok && drive_en;
            refused_r <= !mode_ok;
        end
    end

    // Checks on the behaviour above.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_fieldbus_cam_off: assert property (fb && is_cam |=> refused_r && !loops_en_r) else $error("cam on fieldbus");
    a_fieldbus_seq_off: assert property (fb && cfg.mode == PCR_TSEQ |-> !pos_go) else $error("seq on fieldbus");
    a_single_target: assert property (pos_go && cfg.mode == PCR_SINGLE
        |=> move_r && target_r == $past(cfg.single_target)) else $error("single target wrong");
    a_analog_ends: assert property (pos_go && cfg.mode == PCR_ANALOG && aux_sample == `PCR_ADC_FULL
        |=> target_r == $past(cfg.analog_max)) else $error("analog top wrong");
    a_select_entry: assert property (pos_go && cfg.mode == PCR_TSEL |=> target_r == $past(tbl_mem[sel2_r]))
        else $error("select entry wrong");
    a_seq_wrap: assert property (pos_go && cfg.mode == PCR_TSEQ && cfg.cyclic && seq_last |=> seq_idx_r == 6'h00)
        else $error("cyclic wrap missed");
    a_input_edge: assert property (cfg.mode == PCR_TINPUT && !in_hit |=> !move_r) else $error("move without edge");
    // A start-launched move is never followed by a second move in the very next cycle.
    a_start_once: assert property (move_r && cfg.mode != PCR_TINPUT && $past(cfg.mode) != PCR_TINPUT
        |=> !move_r) else $error("edge seen twice");
    a_master_wrap: assert property (master_pos_r < act.master_mod || !is_cam || $changed(cam_sel))
        else $error("master beyond module");
    // Cam points are not reset, so the bound is only meaningful while a loaded cam is engaged.
    a_slave_bound: assert property (cam_engaged_r |-> slave_pos <= act.slave_mod)
        else $error("slave beyond module");
    a_loops_follow: assert property (drive_en && mode_ok |=> loops_en_r) else $error("loops not run");

    c_table_select: cover property (move_r && cfg.mode == PCR_TSEL);
    c_seq_done: cover property (seq_done_r);
    c_cam_engage: cover property (!cam_engaged_r ##1 cam_engaged_r);
    c_master_wrap: cover property (master_pos_r == mmax ##1 master_pos_r == 32'h00000000);
endmodule

//--- tb/pcr_master_model.sv
// Master axis model: drives the two reference pins as an encoder pair or as pulse and direction.
// Assumes the bench calls turn() from its main sequence and that the pins idle otherwise.
`timescale 1ns/1ps
module pcr_master_model (
    input wire logic sys_clk,
    output logic quadrature_a,
    output logic quadrature_b
);
    // Gray state of the pair, channel A in the upper bit; A leads B when turning forward.
    logic [1:0] ph;

    // Both channels rest low until the first count is asked for.
    initial begin
        ph = 2'b00;
        quadrature_a = 1'b0;
        quadrature_b = 1'b0;
    end

    // quadrature master reference
    // Each call emits n single-channel edges; gap sets the pace, so slow and prompt masters are both possible.
    // Only one channel moves per step, because a real encoder never flips both at once.
    task automatic turn(input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            repeat (gap) @(posedge sys_clk);
            ph = {~ph[0], ph[1]};
            quadrature_a <= ph[1];
            quadrature_b <= ph[0];
        end
    endtask

    // pulse and direction master reference
    // Direction settles on channel A before each pulse on channel B; with fwd low the pins end at rest.
    task automatic pulse(input int n, input int gap, input logic fwd);
        for (int i = 0; i < n; i++) begin
            repeat (gap) @(posedge sys_clk);
            quadrature_a <= fwd;
            repeat (gap) @(posedge sys_clk);
            quadrature_b <= 1'b1;
            repeat (gap) @(posedge sys_clk);
            quadrature_b <= 1'b0;
        end
    endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the positioner and cam target generator.
// Assumes the master model drives the reference pins and the bench drives everything else.
`timescale 1ns/1ps
`define CHK(act, exp, msg) begin num_checks++; if ((act) !== (exp)) begin failures++; \
    $display("CHECK FAILED t=%0t %s", $time, msg); end end
module tb
    import pcr_pkg::*;
;
    logic sys_clk, sys_rst, drive_en, start_in, tbl_we, cam_we, par_we, engage_req;
    pcr_cfg_s cfg;
    pcr_cam_par_s par_wdata;
    logic [11:0] aux_sample, s12;
    logic [15:0] main_speed, cam_wdata, enc_num, enc_den, speed_ref_r;
    logic [5:0] sel_in, tbl_addr, s6;
    logic [7:0] istart_in, istart_en;
    logic [31:0] tbl_data, engage_pos, disengage_pos, phase_off, target_r, master_pos_r;
    logic [2:0] cam_wsel, cam_sel;
    logic [9:0] cam_widx;
    logic quadrature_a, quadrature_b, move_r, loops_en_r, refused_r, seq_done_r, cam_engaged_r;
    pcr_prof_e profile_r;
    // Expected move targets, oldest first, plus a copy of the table contents.
    logic [31:0] exp_q[$];
    logic [31:0] tbl[64];
    int failures = 0;
    int num_checks = 0;

    pcr_top dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .cfg(cfg), .drive_en(drive_en),
        .aux_sample(aux_sample), .main_speed(main_speed), .start_in(start_in), .sel_in(sel_in),
        .istart_in(istart_in), .istart_en(istart_en), .tbl_we(tbl_we), .tbl_addr(tbl_addr),
        .tbl_data(tbl_data), .cam_we(cam_we), .cam_wsel(cam_wsel), .cam_widx(cam_widx),
        .cam_wdata(cam_wdata), .par_we(par_we), .par_wdata(par_wdata), .cam_sel(cam_sel),
        .enc_num(enc_num), .enc_den(enc_den), .engage_req(engage_req), .engage_pos(engage_pos),
        .disengage_pos(disengage_pos), .phase_off(phase_off), .quadrature_a(quadrature_a),
        .quadrature_b(quadrature_b), .target_r(target_r), .move_r(move_r), .speed_ref_r(speed_ref_r),
        .profile_r(profile_r), .loops_en_r(loops_en_r), .refused_r(refused_r), .seq_done_r(seq_done_r),
        .cam_engaged_r(cam_engaged_r), .master_pos_r(master_pos_r));

    pcr_master_model ctl_u (.sys_clk(sys_clk), .quadrature_a(quadrature_a), .quadrature_b(quadrature_b));

    // The clock runs at 40 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // A start held for several cycles must still launch a single move.
    task automatic start_cmd();
        @(posedge sys_clk);
        start_in <= 1'b1;
        tick(4);
        start_in <= 1'b0;
        tick(4);
    endtask

    task automatic go(input logic [31:0] e);
        exp_q.push_back(e);
        start_cmd();
    endtask

    // A mid-run reset clears the sequence pointer and returns the per-cam parameters to their reset values.
    task automatic rst_pulse();
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        tick(3);
        sys_rst <= 1'b0;
        tick(3);
    endtask

    task automatic wr_tbl(input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {tbl_we, tbl_addr, tbl_data} <= {1'b1, a, d};
        @(posedge sys_clk);
        tbl_we <= 1'b0;
    endtask

    task automatic wr_pt(input logic [9:0] i, input logic [15:0] v);
        @(posedge sys_clk);
        {cam_we, cam_wsel, cam_widx, cam_wdata} <= {1'b1, 3'h2, i, v};
        @(posedge sys_clk);
        cam_we <= 1'b0;
    endtask

    task automatic final_report();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Every move pulse takes the oldest expected target; a move nobody asked for is a fault.
    always @(posedge sys_clk) begin
        if (move_r === 1'b1) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("CHECK FAILED t=%0t unexpected move", $time);
            end else `CHK(target_r, exp_q.pop_front(), "move target")
        end
    end

    // A hang is cut short well beyond the fewer than a thousand cycles the tests need.
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        final_report();
    end

    initial begin
        void'($urandom(61));
        {sys_rst, drive_en, start_in, tbl_we, cam_we, par_we, engage_req} = 7'h40;
        cfg = '0;
        par_wdata = '0;
        {aux_sample, main_speed, cam_wdata, enc_num, enc_den, sel_in, tbl_addr} = '0;
        {istart_in, istart_en, tbl_data, engage_pos, disengage_pos, phase_off} = '0;
        {cam_wsel, cam_sel, cam_widx} = '0;
        tick(8);
        sys_rst <= 1'b0;
        tick(4);
        for (int i = 0; i < 64; i++) begin
            tbl[i] = $urandom;
            wr_tbl(6'(i), tbl[i]);
        end
        drive_en <= 1'b1;
        {cfg.single_target, cfg.int_speed, main_speed} <= {32'h00012345, 16'h0abc, 16'h1357};
        go(32'h00012345);
        `CHK(speed_ref_r, 16'h0abc, "internal speed")
        `CHK(loops_en_r, 1'b1, "loops on")
        cfg.spd_analog <= 1'b1;
        tick(3);
        `CHK(speed_ref_r, 16'h1357, "analog speed")
        drive_en <= 1'b0;
        start_cmd();
        `CHK(loops_en_r, 1'b0, "loops off")
        drive_en <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            cfg.profile <= pcr_prof_e'(p);
            tick(3);
            `CHK(profile_r, pcr_prof_e'(p), "profile")
        end
        $display("single target test done");
        cfg.mode <= PCR_ANALOG;
        {cfg.analog_min, cfg.analog_max} <= {32'h000003e8, 32'h000103d8};
        for (int k = 0; k < 3; k++) begin
            s12 = (k == 0) ? 12'h000 : (k == 1) ? 12'hfff : 12'($urandom);
            aux_sample <= s12;
            tick(3);
            go(32'h000003e8 + {s12, 4'h0});
        end
        cfg.mode <= PCR_TSEL;
        for (int k = 0; k < 6; k++) begin
            s6 = (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : 6'($urandom);
            sel_in <= s6;
            tick(3);
            go(tbl[s6]);
        end
        $display("analog and select test done");
        cfg.mode <= PCR_TSEQ;
        {cfg.cyclic, cfg.seq_len} <= {1'b1, 7'h03};
        rst_pulse();
        for (int k = 0; k < 4; k++) go(tbl[k % 3]);
        cfg.cyclic <= 1'b0;
        rst_pulse();
        for (int k = 0; k < 3; k++) go(tbl[k]);
        start_cmd();
        `CHK(seq_done_r, 1'b1, "sequence end")
        $display("sequence test done");
        cfg.src <= PCR_SRC_FIELDBUS;
        tick(3);
        `CHK(refused_r, 1'b1, "sequence on fieldbus")
        start_cmd();
        cfg.mode <= PCR_CAM;
        tick(3);
        `CHK(refused_r, 1'b1, "cam on fieldbus")
        cfg.mode <= PCR_TSEL;
        sel_in <= 6'h05;
        tick(3);
        `CHK(refused_r, 1'b0, "select on fieldbus")
        go(tbl[5]);
        cfg.src <= PCR_SRC_SERIAL;
        cfg.mode <= PCR_TINPUT;
        istart_en <= 8'h0a;
        exp_q.push_back(tbl[1]);
        exp_q.push_back(tbl[3]);
        exp_q.push_back(tbl[1]);
        for (int i = 0; i < 4; i++) begin
            istart_in <= (i == 0) ? 8'h02 : (i == 1) ? 8'h0b : (i == 2) ? 8'h00 : 8'h0a;
            tick(6);
        end
        // Pins back low, so the reset below cannot present a false rising edge.
        istart_in <= 8'h00;
        `CHK(exp_q.size(), 0, "all moves seen")
        $display("fieldbus and input start test done");
        // cam table two with three points, master module eight
        rst_pulse();
        for (int i = 0; i < 3; i++) wr_pt(10'(i), (i == 0) ? 16'h0000 : (i == 1) ? 16'h8000 : 16'hffff);
        @(posedge sys_clk);
        {par_we, cam_wsel} <= {1'b1, 3'h2};
        par_wdata <= '{16'h0001, 16'h0001, 32'h00000008, 32'h0000ffff, 10'h003, 1'b1};
        @(posedge sys_clk);
        par_we <= 1'b0;
        cfg.src <= PCR_SRC_IO;
        cfg.mode <= PCR_CAM;
        {cam_sel, enc_num, enc_den} <= {3'h2, 16'h0001, 16'h0002};
        {phase_off, engage_pos, disengage_pos, engage_req} <= {32'h00000100, 32'h0, 32'h00000006, 1'b1};
        tick(8);
        `CHK(cam_engaged_r, 1'b1, "engaged at zero")
        `CHK(target_r, 32'h00000100, "first point")
        ctl_u.turn(2, 4);
        tick(10);
        `CHK(target_r, 32'h000014ff, "cubic blend")
        ctl_u.turn(6, 4);
        tick(10);
        `CHK(master_pos_r, 32'h00000004, "scaled master")
        `CHK(target_r, 32'h000080ff, "middle point")
        ctl_u.turn(8, 2);
        tick(10);
        `CHK(master_pos_r, 32'h00000000, "master wrap")
        `CHK(target_r, 32'h00000100, "profile repeats")
        engage_req <= 1'b0;
        ctl_u.turn(12, 2);
        tick(10);
        `CHK(cam_engaged_r, 1'b0, "disengaged")
        // Pulse and direction reference, counting backwards from six.
        cfg.pulse_dir <= 1'b1;
        ctl_u.pulse(4, 2, 1'b0);
        tick(10);
        `CHK(master_pos_r, 32'h00000004, "pulse direction")
        $display("cam test done");
        final_report();
    end
endmodule
